// ==== design/lvrd_pkg.sv ====
// Purpose: constants for the low voltage reset and detect block
// Assumes: 200 MHz system clock
// Notes: register map, field positions and timing counts
`default_nettype none
package lvrd_pkg;
	localparam logic [7:0] CTRL_ADDR = 8'h09;
	localparam logic [7:0] IRQ_STATUS_ADDR = 8'h0A;
	localparam logic [7:0] IRQ_MASK_ADDR = 8'h0B;
	localparam int TAP_LSB = 0;
	localparam int TAP_W = 3;
	localparam int DET_EN_BIT = 3;
	localparam int FAST_XTAL_BIT = 4;
	localparam int DET_FLAG_BIT = 5;
	localparam int CLK_PERIOD_PS = 5000;
	localparam int LVR_TIME_US = 1000;
	// One clock beyond the limit, so exactly 1 ms of low supply is still ignored
	localparam int LVR_CYCLES = (LVR_TIME_US * 1000000) / CLK_PERIOD_PS + 1;
	localparam int STARTUP_CYCLES = 1024;
	localparam int LVR_CNT_W = 18;
	localparam int SST_CNT_W = 11;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam int IRQ_W = 2;
	localparam int IRQ_DET_BIT = 0;
	localparam int IRQ_LVR_BIT = 1;
endpackage
`default_nettype wire

// ==== design/tap_select.sv ====
// Purpose: registered eight to one selector for the prescaler taps
// Assumes: taps synchronous to sys_clk
// Notes: output comes from a flip-flop
`default_nettype none
module tap_select (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [7:0] taps,
	input wire logic [2:0] sel,
	output logic out_q
);
	logic out_d;

	// Pick one tap
	always_comb begin
		out_d = taps[sel];
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			out_q <= 1'b0;
		end else begin
			out_q <= out_d;
		end
	end
endmodule
`default_nettype wire

// ==== design/low_voltage_reset_detect.sv ====
// Purpose: low voltage reset, supply drop detector and their control register
// Assumes: low_supply and halt synchronous to sys_clk
// Notes: Function
// Function
// - Options enable low voltage reset and detector separately; disabled detector ignores software.
// - Control bit 3 turns the supply drop detector on or off.
// - Bit 5 reads detector flag, one on low supply; writes ignored.
// - Bits 0 to 2 select one of eight prescaler taps.
// - Bit 4 picks oscillator start-up: zero slow, one quick.
// - Bits 6 and 7 read as zero.
// - Low voltage reset and external clear pin are ORed into chip reset.
// - In HALT both reset and detector are off.
// - Reset only after low supply lasts longer than 1 ms.
// - After reset release, hold chip for 1024 clocks.
//
// The strobed register port was decided locally.
`default_nettype none
module low_voltage_reset_detect #(
	parameter int LVR_LIMIT = lvrd_pkg::LVR_CYCLES
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [7:0] rdata_q,
	input wire logic lvr_option,
	input wire logic lvd_option,
	input wire logic low_supply,
	input wire logic halt,
	input wire logic external_clear_pin,
	input wire logic [7:0] prescaler_taps,
	output logic rtc_out_q,
	output logic fast_xtal_start_q,
	output logic detector_on_q,
	output logic chip_reset_q,
	output logic cpu_hold_q,
	output logic irq_q
);
	typedef enum logic [2:0] {
		ST_RESET = 3'h1,
		ST_STARTUP = 3'h2,
		ST_RUN = 3'h4
	} seq_e;

	seq_e state_q, state_d;
	logic [7:0] ctrl_q, ctrl_d;
	logic flag_q, flag_d;
	logic [lvrd_pkg::LVR_CNT_W-1:0] lvr_cnt_q, lvr_cnt_d;
	logic [lvrd_pkg::SST_CNT_W-1:0] sst_cnt_q, sst_cnt_d;
	logic [lvrd_pkg::IRQ_W-1:0] irq_stat_q, irq_stat_d, irq_mask_q, irq_mask_d, irq_set;
	logic [7:0] rdata_d;
	logic lvr_fire, det_live, reset_src, det_on_d, flag_rise, lvr_rise, lvr_prev_q;

	assign det_live = lvd_option && ctrl_q[lvrd_pkg::DET_EN_BIT] && !halt;
	// longer than 1 ms
	// Gated by option and HALT as well, so a saturated count cannot reset the chip in the HALT entry cycle
	assign lvr_fire = lvr_option && !halt && (lvr_cnt_q >= lvrd_pkg::LVR_CNT_W'(LVR_LIMIT));
	assign reset_src = lvr_fire || external_clear_pin;

	// Low supply duration counter; saturates so the reset stays while low
	always_comb begin
		lvr_cnt_d = lvr_cnt_q;
		// counter off in HALT or when option off
		if (!lvr_option || halt || !low_supply) begin
			lvr_cnt_d = '0;
		end else if (!lvr_fire) begin
			lvr_cnt_d = lvr_cnt_q + 1'b1;
		end
	end

	// Control register and flag; writes to bits 5..7 are dropped
	always_comb begin
		ctrl_d = ctrl_q;
		irq_mask_d = irq_mask_q;
		if (wr_en && addr == lvrd_pkg::CTRL_ADDR) begin
			ctrl_d = {3'h0, wdata[4:0]};
		end
		if (wr_en && addr == lvrd_pkg::IRQ_MASK_ADDR) begin
			irq_mask_d = wdata[lvrd_pkg::IRQ_W-1:0];
		end
		// flag forced low while detector off
		flag_d = det_live && low_supply;
		det_on_d = det_live;
	end

	// Sticky events; a set in the clear cycle wins
	assign flag_rise = flag_d && !flag_q;
	assign lvr_rise = lvr_fire && !lvr_prev_q;
	always_comb begin
		irq_set = '0;
		irq_set[lvrd_pkg::IRQ_DET_BIT] = flag_rise;
		irq_set[lvrd_pkg::IRQ_LVR_BIT] = lvr_rise;
		irq_stat_d = irq_stat_q;
		if (wr_en && addr == lvrd_pkg::IRQ_STATUS_ADDR) begin
			irq_stat_d = irq_stat_q & ~wdata[lvrd_pkg::IRQ_W-1:0];
		end
		irq_stat_d = irq_stat_d | irq_set;
	end

	// Read mux, data one cycle after the strobe
	always_comb begin
		rdata_d = 8'h00;
		if (rd_en) begin
			unique case (addr)
				lvrd_pkg::CTRL_ADDR: begin
					// flag in bit 5, top bits zero
					rdata_d = ctrl_q;
					rdata_d[lvrd_pkg::DET_FLAG_BIT] = flag_q;
				end
				lvrd_pkg::IRQ_STATUS_ADDR: rdata_d = {6'h00, irq_stat_q};
				lvrd_pkg::IRQ_MASK_ADDR: rdata_d = {6'h00, irq_mask_q};
				default: rdata_d = 8'h00;
			endcase
		end
	end

	// Reset and start-up sequencer
	always_comb begin
		state_d = state_q;
		sst_cnt_d = sst_cnt_q;
		unique case (state_q)
			ST_RESET: begin
				sst_cnt_d = '0;
				if (!reset_src) begin
					state_d = ST_STARTUP;
				end
			end
			ST_STARTUP: begin
				if (reset_src) begin
					state_d = ST_RESET;
				end else if (sst_cnt_q == lvrd_pkg::SST_CNT_W'(lvrd_pkg::STARTUP_CYCLES - 1)) begin
					state_d = ST_RUN;
				end else begin
					sst_cnt_d = sst_cnt_q + 1'b1;
				end
			end
			ST_RUN: begin
				if (reset_src) begin
					state_d = ST_RESET;
				end
			end
			default: state_d = ST_RESET;
		endcase
	end

	// Register all state
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state_q <= ST_RESET;
			sst_cnt_q <= '0;
			lvr_cnt_q <= '0;
			ctrl_q <= lvrd_pkg::CTRL_RESET;
			flag_q <= 1'b0;
			lvr_prev_q <= 1'b0;
			irq_stat_q <= '0;
			irq_mask_q <= '0;
			rdata_q <= 8'h00;
			fast_xtal_start_q <= 1'b0;
			detector_on_q <= 1'b0;
			chip_reset_q <= 1'b1;
			cpu_hold_q <= 1'b1;
			irq_q <= 1'b0;
		end else begin
			state_q <= state_d;
			sst_cnt_q <= sst_cnt_d;
			lvr_cnt_q <= lvr_cnt_d;
			ctrl_q <= ctrl_d;
			flag_q <= flag_d;
			lvr_prev_q <= lvr_fire;
			irq_stat_q <= irq_stat_d;
			irq_mask_q <= irq_mask_d;
			rdata_q <= rdata_d;
			fast_xtal_start_q <= ctrl_d[lvrd_pkg::FAST_XTAL_BIT];
			detector_on_q <= det_on_d;
			chip_reset_q <= reset_src;
			cpu_hold_q <= (state_d != ST_RUN);
			irq_q <= |(irq_stat_d & irq_mask_d);
		end
	end

	tap_select u_tap (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.taps(prescaler_taps),
		.sel(ctrl_q[lvrd_pkg::TAP_LSB +: lvrd_pkg::TAP_W]),
		.out_q(rtc_out_q)
	);

	// Checks on the reset paths, the register and the event logic.
	// They sit beside the logic so a broken gate shows up at the cycle it goes wrong.

	chk_ext_reset: assert property (@(posedge sys_clk) disable iff (!rst_n)
		external_clear_pin |=> chip_reset_q)
		else $error("external clear did not reset");

	chk_flag_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(!lvd_option || halt) |=> !flag_q)
		else $error("flag set while detector off");

	chk_halt_noreset: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(halt && !external_clear_pin) |=> !chip_reset_q)
		else $error("reset in halt");

	chk_halt_det_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
		halt |=> !detector_on_q)
		else $error("detector powered in halt");

	chk_lvr_option_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(!lvr_option && !external_clear_pin) |=> !chip_reset_q)
		else $error("reset with option off");

	chk_short_low: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(lvr_cnt_q == '0 && !external_clear_pin) |=> !chip_reset_q)
		else $error("early reset");

	chk_lvr_fires: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(lvr_option && !halt && lvr_cnt_q == lvrd_pkg::LVR_CNT_W'(LVR_LIMIT)) |=> chip_reset_q)
		else $error("no low voltage reset");

	chk_startup_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$fell(chip_reset_q) |-> cpu_hold_q[*8])
		else $error("hold released early");

	chk_startup_end: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(state_q == ST_STARTUP && sst_cnt_q == lvrd_pkg::SST_CNT_W'(lvrd_pkg::STARTUP_CYCLES - 1) && !reset_src)
		|=> !cpu_hold_q)
		else $error("hold not released");

	chk_top_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$past(rd_en) |-> (($past(addr) != lvrd_pkg::CTRL_ADDR) || rdata_q[7:6] == 2'h0))
		else $error("unused bits nonzero");

	chk_flag_ro: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(wr_en && addr == lvrd_pkg::CTRL_ADDR) |=> (ctrl_q[7:5] == 3'h0))
		else $error("read-only bits written");

	chk_det_enable: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(lvd_option && !halt && ctrl_q[lvrd_pkg::DET_EN_BIT]) |=> detector_on_q)
		else $error("detector off");

	chk_xtal_follow: assert property (@(posedge sys_clk) disable iff (!rst_n)
		fast_xtal_start_q == ctrl_q[lvrd_pkg::FAST_XTAL_BIT])
		else $error("start-up mode differs from control bit");

	// Interrupt level tracks unmasked status
	chk_irq_level: assert property (@(posedge sys_clk) disable iff (!rst_n)
		irq_q == |(irq_stat_q & irq_mask_q))
		else $error("interrupt level wrong");

	// Read data idle low outside the answer cycle
	chk_rdata_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!rd_en |=> (rdata_q == 8'h00))
		else $error("read data not idle");

	// Scenarios worth seeing at least once
	cov_lvr: cover property (@(posedge sys_clk) disable iff (!rst_n) lvr_rise);
	cov_flag: cover property (@(posedge sys_clk) disable iff (!rst_n) flag_rise);
	cov_run: cover property (@(posedge sys_clk) disable iff (!rst_n) $fell(cpu_hold_q));
	cov_ext: cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(external_clear_pin));
endmodule
`default_nettype wire

// ==== sim/low_voltage_reset_detect_test.sv ====
// Purpose: self-checking bench for the low voltage reset and detect block
// Assumes: design assertions run alongside; count limit shortened to 20
// Notes: table rows cover the control register, then hand-written reset cases
`default_nettype none
module low_voltage_reset_detect_test;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int LIM = 20;
	logic sys_clk = 1'b0, rst_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, taps = 8'h96;
	logic lvr_option = 1'b0, lvd_option = 1'b0, low_supply = 1'b0, halt = 1'b0, ext_clr = 1'b0;
	logic [7:0] rdata_q;
	logic rtc_out_q, fast_xtal_start_q, detector_on_q, chip_reset_q, cpu_hold_q, irq_q;
	int fails = 0, cmp_count = 0, n;
	// Rows: option, halt, low supply, written byte, expected read byte
	logic [18:0] rows [6] = '{{3'b101, 8'hFF, 8'h3F}, {3'b101, 8'hF7, 8'h17}, {3'b001, 8'h08, 8'h08},
		{3'b111, 8'h0A, 8'h0A}, {3'b100, 8'h0D, 8'h0D}, {3'b101, 8'hC9, 8'h29}};
	low_voltage_reset_detect #(.LVR_LIMIT(LIM)) dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .addr(addr),
		.wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata_q(rdata_q), .lvr_option(lvr_option),
		.lvd_option(lvd_option), .low_supply(low_supply), .halt(halt), .external_clear_pin(ext_clr),
		.prescaler_taps(taps), .rtc_out_q(rtc_out_q), .fast_xtal_start_q(fast_xtal_start_q),
		.detector_on_q(detector_on_q), .chip_reset_q(chip_reset_q), .cpu_hold_q(cpu_hold_q), .irq_q(irq_q));
	// Free-running system clock, 5 ns period
	always #2.5 sys_clk = ~sys_clk;
	// Compare and count; case inequality so unknowns never match
	task chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task print_verdict;
		if (fails == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task cyc(input int k);
		repeat (k) @(posedge sys_clk);
		#1;
	endtask
	// One-cycle write strobe
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge sys_clk);
		wr_en <= 1'b0;
	endtask
	// Read data stands only in the cycle after the strobe
	task rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
		@(posedge sys_clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge sys_clk);
		rd_en <= 1'b0;
		#1;
		chk(rdata_q & m, exp);
	endtask
	// Bounded wait on chip reset level; n returns cycles taken
	task wait_rst(input logic lvl, input int max);
		n = 0;
		while (chip_reset_q !== lvl) begin
			cyc(1);
			n++;
			if (n > max) begin
				chk(8'h00, 8'h01);
				print_verdict();
			end
		end
	endtask
	initial begin
		cyc(16);
		chk(chip_reset_q, 1'b1);
		rst_n <= 1'b1;
		rd(lvrd_pkg::CTRL_ADDR, 8'hFF, lvrd_pkg::CTRL_RESET);
		// Table of register settings against flag, power, taps and start-up bit
		foreach (rows[i]) begin
			{lvd_option, halt, low_supply} <= rows[i][18:16];
			wr(lvrd_pkg::CTRL_ADDR, rows[i][15:8]);
			cyc(3);
			rd(lvrd_pkg::CTRL_ADDR, 8'hFF, rows[i][7:0]);
			chk(detector_on_q, rows[i][18] & rows[i][11] & ~rows[i][17]);
			chk(fast_xtal_start_q, rows[i][12]);
			chk(rtc_out_q, taps[rows[i][10:8]]);
		end
		{lvd_option, halt, low_supply} <= 3'b100;
		rd(8'h33, 8'hFF, 8'h00);
		// Flag rise is latched; mask gates the level output
		rd(lvrd_pkg::IRQ_STATUS_ADDR, 8'h01, 8'h01);
		chk(irq_q, 1'b0);
		wr(lvrd_pkg::IRQ_MASK_ADDR, 8'h01);
		cyc(2);
		chk(irq_q, 1'b1);
		wr(lvrd_pkg::IRQ_STATUS_ADDR, 8'h01);
		cyc(2);
		chk(irq_q, 1'b0);
		// Short low-voltage episode must not reset
		lvr_option <= 1'b1;
		low_supply <= 1'b1;
		cyc(LIM - 5);
		low_supply <= 1'b0;
		cyc(5);
		chk(chip_reset_q, 1'b0);
		// Low supply with the reset option off never resets
		lvr_option <= 1'b0;
		low_supply <= 1'b1;
		cyc(2 * LIM);
		chk(chip_reset_q, 1'b0);
		low_supply <= 1'b0;
		lvr_option <= 1'b1;
		cyc(2);
		// Low supply while halted never resets
		halt <= 1'b1;
		low_supply <= 1'b1;
		cyc(2 * LIM);
		chk(chip_reset_q, 1'b0);
		low_supply <= 1'b0;
		halt <= 1'b0;
		cyc(2);
		// Long episode resets after the limit, then start-up hold
		low_supply <= 1'b1;
		wait_rst(1'b1, LIM + 10);
		chk(n >= LIM && n <= LIM + 3, 1'b1);
		low_supply <= 1'b0;
		wait_rst(1'b0, 5);
		n = 0;
		while (cpu_hold_q === 1'b1 && n < 1200) begin
			cyc(1);
			n++;
		end
		chk(n >= 1020 && n <= 1030, 1'b1);
		// External clear alone resets the chip
		ext_clr <= 1'b1;
		wait_rst(1'b1, 3);
		chk(cpu_hold_q, 1'b1);
		ext_clr <= 1'b0;
		wait_rst(1'b0, 5);
		print_verdict();
	end
endmodule
`default_nettype wire
